// ---- rtl/rmc_dev.sv ----
// rmc_dev: radio module end; stores feature, service and connection settings
// assumes: rmc_if carrier; reboot is a one-cycle pulse from the system reboot logic
//
// Operation
// - feature bitmap stored, applied at next reboot
// - bit 15 enables hardware flow control
// - bit 14 suppresses ready prompt
// - bit 13: mode pin only, no escape scan
// - bits 12,10,9: beacon, duplicate, passive scan
// - bit 11 drops connectable adverts from scan
// - host sets no-duplicate bit for changing adverts
// - bit 8 selects unacknowledged serial writes
// - bit 7 reboots after link disconnect
// - bit 6 autostarts script at reboot
// - bit 5 enables legacy stream service
// - bit 4 disables long packets, newer firmware
// - bit 3 guards escape by one second
// - feature default 0000, A000 works
// - service bitmap stored, applied after reboot
// - service bits 80,40,20,10; default 00
// - service command deletes custom services
// - four connection params stored in order
// - query returns stored or negotiated params
// - intervals 0006..0c80, max not below min
// - latency range and timeout relation
// - timeout 000a..0c80
`timescale 1ns/1ns
module rmc_dev #(
   parameter int FW_REV = rmc_pkg::FW_REV_DEF,
   parameter int GUARD_CYC = rmc_pkg::GUARD_CYC
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   rmc_if.dev lnk,
   input wire logic reboot,
   input wire logic link_up,
   input wire logic [63:0] link_params,
   input wire logic data_byte,
   input wire logic esc_done,
   input wire logic mode_pin_fall,
   output logic flow_ctrl_en_q,
   output logic escape_scan_en_q,
   output logic drop_beacon_q,
   output logic drop_connectable_q,
   output logic keep_duplicates_q,
   output logic passive_scan_q,
   output logic write_no_ack_q,
   output logic legacy_stream_service_en_q,
   output logic long_packet_extension_en_q,
   output logic auto_script_start_q,
   output logic reboot_req_q,
   output logic [7:0] svc_active_q,
   output logic purge_custom_q,
   output logic enter_cmd_q,
   output logic pass_through_q
);
   initial begin
      if (GUARD_CYC < 2 || GUARD_CYC >= (1 << rmc_pkg::GUARD_W)) $error("GUARD_CYC out of range");
   end
   localparam logic [15:0] FEAT_MASK = (FW_REV >= rmc_pkg::FW_REV_GUARD) ? 16'hffff : 16'hffe7;
   localparam logic [rmc_pkg::GUARD_W-1:0] GUARD_LIM = rmc_pkg::GUARD_W'(GUARD_CYC);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_PROMPT = 2'b10
   } rmc_dst_e;
   typedef enum logic [1:0] {
      GD_IDLE = 2'b00,
      GD_POST = 2'b01
   } rmc_gst_e;

   rmc_dst_e state_q;
   rmc_pkg::rmc_op_e op_q;
   logic [2:0] argc_q;
   logic [63:0] args_q;
   logic [15:0] feat_store_q;
   logic [15:0] feat_active_q;
   logic [7:0] svc_store_q;
   logic [63:0] conn_q;
   logic cmd_ready_q;
   logic rsp_valid_q;
   rmc_pkg::rmc_rsp_e rsp_code_q;
   logic [63:0] rsp_data_q;
   logic prompt_q;
   logic params_ok;
   logic accept;
   logic link_up_q;

   assign lnk.cmd_ready = cmd_ready_q;
   assign lnk.rsp_valid = rsp_valid_q;
   assign lnk.rsp_code = rsp_code_q;
   assign lnk.rsp_data = rsp_data_q;
   assign lnk.prompt = prompt_q;

   rmc_param_check u_chk (
      .int_min(args_q[15:0]),
      .int_max(args_q[31:16]),
      .latency(args_q[47:32]),
      .timeout(args_q[63:48]),
      .ok(params_ok)
   );

   always_comb begin
      case (op_q)
         rmc_pkg::OP_FEAT: accept = (argc_q == rmc_pkg::ARGC_SR);
         rmc_pkg::OP_SVC: accept = (argc_q == rmc_pkg::ARGC_SS) && (args_q[15:8] == 8'h00)
            && ((args_q[7:0] & ~rmc_pkg::SVC_LEGAL) == 8'h00);
         rmc_pkg::OP_SET_CONN: accept = (argc_q == rmc_pkg::ARGC_ST) && params_ok;
         default: accept = (argc_q == rmc_pkg::ARGC_GT);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         cmd_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         prompt_q <= 1'b0;
         op_q <= rmc_pkg::OP_FEAT;
         argc_q <= 3'h0;
         args_q <= 64'h0;
         rsp_code_q <= rmc_pkg::RSP_AOK;
         rsp_data_q <= 64'h0;
      end else if (ce) begin
         rsp_valid_q <= 1'b0;
         prompt_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               cmd_ready_q <= 1'b1;
               if (lnk.cmd_valid && cmd_ready_q) begin
                  cmd_ready_q <= 1'b0;
                  op_q <= lnk.cmd_op;
                  argc_q <= lnk.cmd_argc;
                  args_q <= lnk.cmd_args;
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               rsp_valid_q <= 1'b1;
               rsp_data_q <= 64'h0;
               if (!accept) begin
                  rsp_code_q <= rmc_pkg::RSP_ERR;
               end else if (op_q == rmc_pkg::OP_GET_CONN) begin
                  rsp_code_q <= rmc_pkg::RSP_DATA;
                  rsp_data_q <= link_up ? link_params : conn_q;
               end else begin
                  rsp_code_q <= rmc_pkg::RSP_AOK;
               end
               state_q <= ST_PROMPT;
            end
            default: begin
               prompt_q <= ~feat_active_q[rmc_pkg::FB_NO_PROMPT];
               cmd_ready_q <= 1'b1;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stored settings
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         feat_store_q <= rmc_pkg::FEAT_RST;
         svc_store_q <= rmc_pkg::SVC_RST;
         conn_q <= {rmc_pkg::TMO_RST, rmc_pkg::LAT_RST, rmc_pkg::MAX_RST, rmc_pkg::MIN_RST};
         purge_custom_q <= 1'b0;
      end else if (ce) begin
         purge_custom_q <= 1'b0;
         if (state_q == ST_EXEC && accept) begin
            case (op_q)
               rmc_pkg::OP_FEAT: feat_store_q <= args_q[15:0] & FEAT_MASK;
               rmc_pkg::OP_SVC: begin
                  svc_store_q <= args_q[7:0];
                  purge_custom_q <= 1'b1;
               end
               rmc_pkg::OP_SET_CONN: conn_q <= args_q;
               default: conn_q <= conn_q;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // active settings, taken over at reboot
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         feat_active_q <= rmc_pkg::FEAT_RST;
         svc_active_q <= rmc_pkg::SVC_RST;
         auto_script_start_q <= 1'b0;
      end else if (ce) begin
         auto_script_start_q <= 1'b0;
         if (reboot) begin
            feat_active_q <= feat_store_q;
            svc_active_q <= svc_store_q;
            auto_script_start_q <= feat_store_q[rmc_pkg::FB_AUTO_SCRIPT];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         flow_ctrl_en_q <= 1'b0;
         escape_scan_en_q <= 1'b1;
         drop_beacon_q <= 1'b0;
         drop_connectable_q <= 1'b0;
         keep_duplicates_q <= 1'b0;
         passive_scan_q <= 1'b0;
         write_no_ack_q <= 1'b0;
         legacy_stream_service_en_q <= 1'b0;
         long_packet_extension_en_q <= 1'b1;
      end else if (ce) begin
         flow_ctrl_en_q <= feat_active_q[rmc_pkg::FB_FLOW];
         escape_scan_en_q <= ~feat_active_q[rmc_pkg::FB_FAST];
         drop_beacon_q <= feat_active_q[rmc_pkg::FB_NO_BEACON];
         drop_connectable_q <= feat_active_q[rmc_pkg::FB_NO_CONN];
         keep_duplicates_q <= feat_active_q[rmc_pkg::FB_NO_DUP];
         passive_scan_q <= feat_active_q[rmc_pkg::FB_PASSIVE];
         write_no_ack_q <= feat_active_q[rmc_pkg::FB_NO_ACK];
         legacy_stream_service_en_q <= feat_active_q[rmc_pkg::FB_LEGACY];
         long_packet_extension_en_q <= ~feat_active_q[rmc_pkg::FB_NO_LONG];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reboot request on link loss
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         link_up_q <= 1'b0;
         reboot_req_q <= 1'b0;
      end else if (ce) begin
         link_up_q <= link_up;
         reboot_req_q <= link_up_q && !link_up && feat_active_q[rmc_pkg::FB_REBOOT_DISC];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command mode entry: escape sequence, guard window, mode pin
   rmc_gst_e gstate_q;
   logic [rmc_pkg::GUARD_W-1:0] quiet_q;
   logic [rmc_pkg::GUARD_W-1:0] wait_q;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         quiet_q <= '0;
      end else if (ce) begin
         if (data_byte) begin
            quiet_q <= '0;
         end else if (quiet_q != GUARD_LIM) begin
            quiet_q <= quiet_q + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         gstate_q <= GD_IDLE;
         wait_q <= '0;
         enter_cmd_q <= 1'b0;
         pass_through_q <= 1'b0;
      end else if (ce) begin
         enter_cmd_q <= 1'b0;
         pass_through_q <= 1'b0;
         case (gstate_q)
            GD_IDLE: begin
               if (feat_active_q[rmc_pkg::FB_FAST]) begin
                  enter_cmd_q <= mode_pin_fall;
               end else if (esc_done) begin
                  if (!feat_active_q[rmc_pkg::FB_GUARD]) begin
                     enter_cmd_q <= 1'b1;
                  end else if (quiet_q != GUARD_LIM) begin
                     pass_through_q <= 1'b1;
                  end else begin
                     wait_q <= '0;
                     gstate_q <= GD_POST;
                  end
               end
            end
            default: begin
               if (data_byte) begin
                  pass_through_q <= 1'b1;
                  gstate_q <= GD_IDLE;
               end else if (wait_q == GUARD_LIM - 1'b1) begin
                  enter_cmd_q <= 1'b1;
                  gstate_q <= GD_IDLE;
               end else begin
                  wait_q <= wait_q + 1'b1;
               end
            end
         endcase
      end
   end
endmodule : rmc_dev

// ---- rtl/rmc_pkg.sv ----
// rmc_pkg: shared constants and types for the radio module configuration command handler
// assumes: both ends and the interface use these by full package name
package rmc_pkg;
   localparam int CLK_MHZ = 250;
   localparam int GUARD_MS = 1000;
   localparam int GUARD_CYC = GUARD_MS * 1000 * CLK_MHZ;
   localparam int GUARD_W = 28;
   localparam int FW_REV_DEF = 128;
   localparam int FW_REV_GUARD = 128;
   // feature bitmap bit positions
   localparam int FB_FLOW = 15;
   localparam int FB_NO_PROMPT = 14;
   localparam int FB_FAST = 13;
   localparam int FB_NO_BEACON = 12;
   localparam int FB_NO_CONN = 11;
   localparam int FB_NO_DUP = 10;
   localparam int FB_PASSIVE = 9;
   localparam int FB_NO_ACK = 8;
   localparam int FB_REBOOT_DISC = 7;
   localparam int FB_AUTO_SCRIPT = 6;
   localparam int FB_LEGACY = 5;
   localparam int FB_NO_LONG = 4;
   localparam int FB_GUARD = 3;
   // service bitmap bit positions
   localparam int SV_DEV_INFO = 7;
   localparam int SV_SERIAL = 6;
   localparam int SV_BEACON = 5;
   localparam int SV_RSVD = 4;
   localparam logic [15:0] FEAT_RST = 16'h0000;
   localparam logic [7:0] SVC_RST = 8'h00;
   localparam logic [7:0] SVC_LEGAL = 8'hf0;
   // connection parameter limits and reset values
   localparam logic [15:0] INT_MIN = 16'h0006;
   localparam logic [15:0] INT_MAX = 16'h0c80;
   localparam logic [15:0] LAT_MAX = 16'h01f3;
   localparam logic [15:0] TMO_MIN = 16'h000a;
   localparam logic [15:0] TMO_MAX = 16'h0c80;
   localparam logic [15:0] MIN_RST = 16'h0006;
   localparam logic [15:0] MAX_RST = 16'h0006;
   localparam logic [15:0] LAT_RST = 16'h0000;
   localparam logic [15:0] TMO_RST = 16'h0200;
   localparam logic [2:0] ARGC_SR = 3'h1;
   localparam logic [2:0] ARGC_SS = 3'h1;
   localparam logic [2:0] ARGC_ST = 3'h4;
   localparam logic [2:0] ARGC_GT = 3'h0;
   typedef enum logic [1:0] {
      OP_FEAT = 2'b00,
      OP_SVC = 2'b01,
      OP_SET_CONN = 2'b10,
      OP_GET_CONN = 2'b11
   } rmc_op_e;
   typedef enum logic [1:0] {
      RSP_AOK = 2'b00,
      RSP_ERR = 2'b01,
      RSP_DATA = 2'b10
   } rmc_rsp_e;
endpackage : rmc_pkg

// ---- rtl/rmc_if.sv ----
// rmc_if: parsed command link between host controller and radio module
// assumes: both ends run on the same mclk; args word n sits at bits 16n+15:16n
`timescale 1ns/1ns
interface rmc_if;
   logic cmd_valid;
   logic cmd_ready;
   rmc_pkg::rmc_op_e cmd_op;
   logic [2:0] cmd_argc;
   logic [63:0] cmd_args;
   logic rsp_valid;
   rmc_pkg::rmc_rsp_e rsp_code;
   logic [63:0] rsp_data;
   logic prompt;
   modport dev (input cmd_valid, cmd_op, cmd_argc, cmd_args,
      output cmd_ready, rsp_valid, rsp_code, rsp_data, prompt);
   modport host (output cmd_valid, cmd_op, cmd_argc, cmd_args,
      input cmd_ready, rsp_valid, rsp_code, rsp_data, prompt);
endinterface : rmc_if

// ---- rtl/rmc_param_check.sv ----
// rmc_param_check: range check of the four connection parameters
// assumes: inputs are stable for the cycle the result is used
`timescale 1ns/1ns
module rmc_param_check (
   input wire logic [15:0] int_min,
   input wire logic [15:0] int_max,
   input wire logic [15:0] latency,
   input wire logic [15:0] timeout,
   output logic ok
);
   logic [32:0] lat_prod;
   logic [32:0] tmo_scaled;
   always_comb begin
      // latency < timeout*10/(interval*1.25) - 1  <=>  (latency+1)*interval < timeout*8
      lat_prod = 33'({17'd0, latency} + 33'd1) * 33'(int_max);
      tmo_scaled = {14'd0, timeout, 3'd0};
      ok = (int_min >= rmc_pkg::INT_MIN) && (int_min <= rmc_pkg::INT_MAX)
         && (int_max >= rmc_pkg::INT_MIN) && (int_max <= rmc_pkg::INT_MAX)
         && (int_max >= int_min)
         && (latency <= rmc_pkg::LAT_MAX) && (lat_prod < tmo_scaled)
         && (timeout >= rmc_pkg::TMO_MIN) && (timeout <= rmc_pkg::TMO_MAX);
   end
endmodule : rmc_param_check

// ---- rtl/rmc_host.sv ----
// rmc_host: host controller end; forwards user requests, pre-checks connection params
// assumes: rmc_if carrier; user holds req_* stable while req_valid and not yet taken
`timescale 1ns/1ns
module rmc_host (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   rmc_if.host lnk,
   input wire logic req_valid,
   input wire rmc_pkg::rmc_op_e req_op,
   input wire logic [2:0] req_argc,
   input wire logic [63:0] req_args,
   input wire logic expect_dynamic,
   output logic req_ready_q,
   output logic res_valid_q,
   output rmc_pkg::rmc_rsp_e res_code_q,
   output logic [63:0] res_data_q,
   output logic prompt_seen_q
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEND = 2'b01,
      H_WAIT = 2'b10
   } rmc_hst_e;

   rmc_hst_e state_q;
   logic cmd_valid_q;
   rmc_pkg::rmc_op_e op_q;
   logic [2:0] argc_q;
   logic [63:0] args_q;
   logic params_ok;

   assign lnk.cmd_valid = cmd_valid_q;
   assign lnk.cmd_op = op_q;
   assign lnk.cmd_argc = argc_q;
   assign lnk.cmd_args = args_q;

   rmc_param_check u_chk (
      .int_min(req_args[15:0]),
      .int_max(req_args[31:16]),
      .latency(req_args[47:32]),
      .timeout(req_args[63:48]),
      .ok(params_ok)
   );

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_q <= H_IDLE;
         req_ready_q <= 1'b0;
         cmd_valid_q <= 1'b0;
         op_q <= rmc_pkg::OP_FEAT;
         argc_q <= 3'h0;
         args_q <= 64'h0;
         res_valid_q <= 1'b0;
         res_code_q <= rmc_pkg::RSP_AOK;
         res_data_q <= 64'h0;
         prompt_seen_q <= 1'b0;
      end else if (ce) begin
         res_valid_q <= 1'b0;
         prompt_seen_q <= lnk.prompt;
         case (state_q)
            H_IDLE: begin
               req_ready_q <= 1'b1;
               if (req_valid && req_ready_q) begin
                  req_ready_q <= 1'b0;
                  if (req_op == rmc_pkg::OP_SET_CONN && !params_ok) begin
                     res_valid_q <= 1'b1;
                     res_code_q <= rmc_pkg::RSP_ERR;
                     res_data_q <= 64'h0;
                  end else begin
                     op_q <= req_op;
                     argc_q <= req_argc;
                     args_q <= req_args;
                     if (req_op == rmc_pkg::OP_FEAT && expect_dynamic) begin
                        args_q[rmc_pkg::FB_NO_DUP] <= 1'b1;
                     end
                     cmd_valid_q <= 1'b1;
                     state_q <= H_SEND;
                  end
               end
            end
            H_SEND: begin
               if (lnk.cmd_ready) begin
                  cmd_valid_q <= 1'b0;
                  state_q <= H_WAIT;
               end
            end
            default: begin
               if (lnk.rsp_valid) begin
                  res_valid_q <= 1'b1;
                  res_code_q <= lnk.rsp_code;
                  res_data_q <= lnk.rsp_data;
                  req_ready_q <= 1'b1;
                  state_q <= H_IDLE;
               end
            end
         endcase
      end
   end
endmodule : rmc_host

// ---- tb/rmc_chk.sv ----
// rmc_chk: concurrent checks on the command link between the two ends
// assumes: instantiated beside rmc_if in the bench, single mclk domain
`timescale 1ns/1ns
module rmc_chk (
   input logic mclk,
   input logic resetn,
   input logic cmd_valid,
   input logic cmd_ready,
   input rmc_pkg::rmc_op_e cmd_op,
   input logic [2:0] cmd_argc,
   input logic [63:0] cmd_args,
   input logic rsp_valid,
   input rmc_pkg::rmc_rsp_e rsp_code,
   input logic [63:0] rsp_data,
   input logic prompt
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   wire take = cmd_valid && cmd_ready;
   logic [2:0] argc_need;
   ////////////////////////////////////////////////////////////////
   always_comb begin
      case (cmd_op)
         rmc_pkg::OP_FEAT: argc_need = rmc_pkg::ARGC_SR;
         rmc_pkg::OP_SVC: argc_need = rmc_pkg::ARGC_SS;
         rmc_pkg::OP_SET_CONN: argc_need = rmc_pkg::ARGC_ST;
         default: argc_need = rmc_pkg::ARGC_GT;
      endcase
   end
   ////////////////////////////////////////////////////////////////
   a_rsp_timing: assert property (take |-> ##2 rsp_valid) else $error("no response two cycles after take");
   a_rsp_cause: assert property (rsp_valid |-> $past(take, 2)) else $error("response without command");
   a_ready_cycle: assert property (take |=> !cmd_ready [*2] ##1 cmd_ready)
      else $error("ready not restored on prompt cycle");
   a_prompt_cause: assert property (prompt |-> $past(rsp_valid)) else $error("prompt not after response");
   a_argc_err: assert property (take && cmd_argc != argc_need |-> ##2 rsp_code == rmc_pkg::RSP_ERR)
      else $error("bad argument count not refused");
   a_get_data: assert property (take && cmd_op == rmc_pkg::OP_GET_CONN && cmd_argc == 3'h0
      |-> ##2 rsp_code == rmc_pkg::RSP_DATA) else $error("query gave no data");
   a_svc_err: assert property (take && cmd_op == rmc_pkg::OP_SVC && (cmd_args[15:8] != 8'h00
      || cmd_args[3:0] != 4'h0) |-> ##2 rsp_code == rmc_pkg::RSP_ERR) else $error("bad service map accepted");
   a_int_range: assert property (take && cmd_op == rmc_pkg::OP_SET_CONN |-> cmd_args[15:0] >= rmc_pkg::INT_MIN
      && cmd_args[31:16] >= cmd_args[15:0] && cmd_args[31:16] <= rmc_pkg::INT_MAX) else $error("interval sent bad");
   a_lat_tmo: assert property (take && cmd_op == rmc_pkg::OP_SET_CONN |-> cmd_args[47:32] <= rmc_pkg::LAT_MAX
      && cmd_args[63:48] >= rmc_pkg::TMO_MIN && cmd_args[63:48] <= rmc_pkg::TMO_MAX) else $error("latency sent bad");
endmodule : rmc_chk

// ---- tb/tb_top.sv ----
// tb_top: bench joining host and radio module ends over the command link
// assumes: rmc_pkg, rmc_if, rmc_dev, rmc_host and rmc_chk compiled first
`timescale 1ns/1ns
module tb_top;
   typedef struct {
      rmc_pkg::rmc_op_e op;
      logic [2:0] argc;
      logic [63:0] args;
      rmc_pkg::rmc_rsp_e code;
      logic [63:0] dat;
   } rmc_row_s;
   logic mclk, resetn, reboot, link_up, data_byte, esc_done, mode_pin_fall, req_valid, expect_dynamic;
   rmc_pkg::rmc_op_e req_op;
   logic [2:0] req_argc;
   logic [63:0] req_args, link_params, res_data_q, got_data;
   logic flow_ctrl_en_q, escape_scan_en_q, drop_beacon_q, drop_connectable_q, keep_duplicates_q, passive_scan_q;
   logic write_no_ack_q, legacy_stream_service_en_q, long_packet_extension_en_q, auto_script_start_q, reboot_req_q;
   logic purge_custom_q, enter_cmd_q, pass_through_q, req_ready_q, res_valid_q, prompt_seen_q;
   logic [7:0] svc_active_q;
   rmc_pkg::rmc_rsp_e res_code_q, got_code;
   int n_fail = 0, comparisons = 0, n_prompt = 0, n_rsp = 0, n_purge = 0, n_auto = 0, n_rboot = 0;
   int n_enter = 0, n_pass = 0, p;
   rmc_row_s rows[$];
   rmc_if lnk();
   rmc_dev #(.GUARD_CYC(20)) rmc_dev_i (.mclk(mclk), .resetn(resetn), .ce(1'b1), .lnk(lnk), .reboot(reboot),
      .link_up(link_up), .link_params(link_params), .data_byte(data_byte), .esc_done(esc_done),
      .mode_pin_fall(mode_pin_fall), .flow_ctrl_en_q(flow_ctrl_en_q), .escape_scan_en_q(escape_scan_en_q),
      .drop_beacon_q(drop_beacon_q), .drop_connectable_q(drop_connectable_q), .keep_duplicates_q(keep_duplicates_q),
      .passive_scan_q(passive_scan_q), .write_no_ack_q(write_no_ack_q),
      .legacy_stream_service_en_q(legacy_stream_service_en_q), .long_packet_extension_en_q(long_packet_extension_en_q),
      .auto_script_start_q(auto_script_start_q), .reboot_req_q(reboot_req_q), .svc_active_q(svc_active_q),
      .purge_custom_q(purge_custom_q), .enter_cmd_q(enter_cmd_q), .pass_through_q(pass_through_q));
   rmc_host rmc_host_i (.mclk(mclk), .resetn(resetn), .ce(1'b1), .lnk(lnk), .req_valid(req_valid), .req_op(req_op),
      .req_argc(req_argc), .req_args(req_args), .expect_dynamic(expect_dynamic), .req_ready_q(req_ready_q),
      .res_valid_q(res_valid_q), .res_code_q(res_code_q), .res_data_q(res_data_q), .prompt_seen_q(prompt_seen_q));
   rmc_chk rmc_chk_i (.mclk(mclk), .resetn(resetn), .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready),
      .cmd_op(lnk.cmd_op), .cmd_argc(lnk.cmd_argc), .cmd_args(lnk.cmd_args), .rsp_valid(lnk.rsp_valid),
      .rsp_code(lnk.rsp_code), .rsp_data(lnk.rsp_data), .prompt(lnk.prompt));
   ////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      n_prompt += (lnk.prompt === 1'b1);
      n_rsp += (lnk.rsp_valid === 1'b1);
      n_purge += (purge_custom_q === 1'b1);
      n_auto += (auto_script_start_q === 1'b1);
      n_rboot += (reboot_req_q === 1'b1);
      n_enter += (enter_cmd_q === 1'b1);
      n_pass += (pass_through_q === 1'b1);
   end
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         n_fail++;
      end
   endtask : check
   task automatic summarize;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task automatic wait_hi(input bit rdy);
      int i;
      for (i = 0; i < 50 && (rdy ? req_ready_q : res_valid_q) !== 1'b1; i++) begin
         @(negedge mclk);
      end
      if (i == 50) begin
         n_fail++;
         summarize();
      end
   endtask : wait_hi
   task automatic req(input rmc_pkg::rmc_op_e op, input logic [2:0] argc, input logic [63:0] args);
      req_op = op;
      req_argc = argc;
      req_args = args;
      req_valid = 1'b1;
      wait_hi(1'b1);
      cyc(1);
      req_valid = 1'b0;
      wait_hi(1'b0);
      got_code = res_code_q;
      got_data = res_data_q;
   endtask : req
   task automatic add(input rmc_pkg::rmc_op_e op, input logic [2:0] argc, input logic [63:0] args,
      input rmc_pkg::rmc_rsp_e code, input logic [63:0] dat);
      rows.push_back('{op, argc, args, code, dat});
   endtask : add
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : pulse
   ////////////////////////////////////////////////////////////////
   initial begin
      {resetn, reboot, link_up, data_byte, esc_done, mode_pin_fall, req_valid, expect_dynamic} = 8'h00;
      req_op = rmc_pkg::OP_GET_CONN;
      req_argc = 3'h0;
      req_args = 64'h0;
      link_params = 64'h0123_0004_0040_0020;
      add(rmc_pkg::OP_GET_CONN, 3'h0, 64'h0, rmc_pkg::RSP_DATA, 64'h0200_0000_0006_0006);
      add(rmc_pkg::OP_SET_CONN, 3'h4, 64'h0064_0002_0064_0020, rmc_pkg::RSP_AOK, 64'h0);
      add(rmc_pkg::OP_SET_CONN, 3'h4, 64'h0064_0002_0064_0005, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_SET_CONN, 3'h4, 64'h0064_0002_0008_0010, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_SET_CONN, 3'h4, 64'h0c80_0000_0c81_0006, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_SET_CONN, 3'h4, 64'h0c80_01f4_0006_0006, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_SET_CONN, 3'h4, 64'h000a_0001_0c80_0006, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_SET_CONN, 3'h4, 64'h0009_0000_0006_0006, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_GET_CONN, 3'h0, 64'h0, rmc_pkg::RSP_DATA, 64'h0064_0002_0064_0020);
      add(rmc_pkg::OP_SET_CONN, 3'h4, 64'h0c80_0000_0c80_0006, rmc_pkg::RSP_AOK, 64'h0);
      add(rmc_pkg::OP_GET_CONN, 3'h0, 64'h0, rmc_pkg::RSP_DATA, 64'h0c80_0000_0c80_0006);
      add(rmc_pkg::OP_GET_CONN, 3'h1, 64'h0, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_FEAT, 3'h2, 64'ha000, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_FEAT, 3'h1, 64'ha000, rmc_pkg::RSP_AOK, 64'h0);
      add(rmc_pkg::OP_SVC, 3'h1, 64'h0001, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_SVC, 3'h1, 64'h01c0, rmc_pkg::RSP_ERR, 64'h0);
      add(rmc_pkg::OP_SVC, 3'h1, 64'h0010, rmc_pkg::RSP_AOK, 64'h0);
      add(rmc_pkg::OP_SVC, 3'h1, 64'h00e0, rmc_pkg::RSP_AOK, 64'h0);
      cyc(16);
      check("reset flags", {flow_ctrl_en_q, escape_scan_en_q, long_packet_extension_en_q}, 3'b011);
      check("reset services", svc_active_q, 8'h00);
      resetn = 1'b1;
      foreach (rows[k]) begin
         req(rows[k].op, rows[k].argc, rows[k].args);
         check("res_code", 64'(got_code), 64'(rows[k].code));
         if (rows[k].code == rmc_pkg::RSP_DATA) check("res_data", got_data, rows[k].dat);
      end
      check("flow before reboot", flow_ctrl_en_q, 1'b0);
      check("services before reboot", svc_active_q, 8'h00);
      check("purges", n_purge, 2);
      cyc(2);
      check("prompts", n_prompt, n_rsp);
      pulse(reboot);
      cyc(2);
      check("flow", flow_ctrl_en_q, 1'b1);
      check("escape scan", escape_scan_en_q, 1'b0);
      check("services", svc_active_q, 8'he0);
      pulse(esc_done);
      cyc(30);
      check("escape ignored", n_enter, 0);
      pulse(mode_pin_fall);
      cyc(3);
      check("mode pin", n_enter, 1);
      expect_dynamic = 1'b1;
      req(rmc_pkg::OP_FEAT, 3'h1, 64'h5bf8);
      expect_dynamic = 1'b0;
      check("flow kept", flow_ctrl_en_q, 1'b1);
      pulse(reboot);
      cyc(2);
      check("flow off", flow_ctrl_en_q, 1'b0);
      check("scan flags", {drop_beacon_q, passive_scan_q, escape_scan_en_q}, 3'b111);
      check("no connectable", drop_connectable_q, 1'b1);
      check("duplicates", keep_duplicates_q, 1'b1);
      check("no ack", write_no_ack_q, 1'b1);
      check("legacy", legacy_stream_service_en_q, 1'b1);
      check("long packets", long_packet_extension_en_q, 1'b0);
      check("script start", n_auto, 1);
      p = n_prompt;
      link_up = 1'b1;
      cyc(2);
      req(rmc_pkg::OP_GET_CONN, 3'h0, 64'h0);
      check("negotiated", got_data, 64'h0123_0004_0040_0020);
      link_up = 1'b0;
      cyc(3);
      check("prompt off", n_prompt, p);
      check("reboot request", n_rboot, 1);
      pulse(esc_done);
      cyc(40);
      check("guard enter", n_enter, 2);
      pulse(data_byte);
      cyc(2);
      pulse(esc_done);
      cyc(40);
      check("guard pass", {n_pass[3:0], n_enter[3:0]}, 8'h12);
      resetn = 1'b0;
      cyc(16);
      check("reset again", {flow_ctrl_en_q, escape_scan_en_q, svc_active_q}, 10'h100);
      resetn = 1'b1;
      req(rmc_pkg::OP_GET_CONN, 3'h0, 64'h0);
      check("reset conn", got_data, 64'h0200_0000_0006_0006);
      summarize();
   end
endmodule : tb_top
